// >>> csv_cmp_event.sv
// Purpose: event flag logic of one comparator
// Assumes: result already synchronised
// Notes:   first event after arming takes any edge
`timescale 1ns/100ps
`default_nettype none
module csv_cmp_event (
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    input  wire logic             present,
    input  wire logic             result,
    input  wire csv_pkg::csv_pol_e polarity,
    input  wire logic             evt_clear,
    output var  logic             out_reg,
    output var  logic             evt_reg
);
    import csv_pkg::*;

    logic armed_first_reg;
    logic rise;
    logic fall;
    logic hit;

    assign rise = result & ~out_reg;
    assign fall = ~result & out_reg;

    always_comb begin
        hit = 1'b0;
        if (armed_first_reg) begin
            hit = rise | fall;
        end else begin
            unique case (polarity)
                CSV_POL_OFF:  hit = 1'b0;
                CSV_POL_RISE: hit = rise;
                CSV_POL_FALL: hit = fall;
                CSV_POL_ANY:  hit = rise | fall;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            out_reg <= 1'b0;
        end else begin
            out_reg <= present & result;
        end
    end

    // any-edge mode until the first event after polarity becomes nonzero
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            armed_first_reg <= 1'b0;
        end else if (polarity == CSV_POL_OFF) begin
            armed_first_reg <= 1'b1;
        end else if (hit) begin
            armed_first_reg <= 1'b0;
        end
    end

    // set wins over clear
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            evt_reg <= 1'b0;
        end else if (!present) begin
            evt_reg <= 1'b0;
        end else if (hit && polarity != CSV_POL_OFF) begin
            evt_reg <= 1'b1;
        end else if (evt_clear) begin
            evt_reg <= 1'b0;
        end
    end
endmodule : csv_cmp_event
`default_nettype wire

// >>> csv_pkg.sv
// Purpose: constants and types for the comparator status and reference register bank
// Assumes: AXI4-Lite, 32-bit data, 16-bit registers in the low half of each word
// Notes:   offsets are byte addresses
//
// Contract
// - channel code picks pin B, C, D, bandgap
// - bandgap level comes from buffer level field
// - first event after nonzero polarity: any edge
// - idle-stop gates interrupts in idle only
// - status bits 10..8 mirror event flags
// - status bits 2..0 mirror comparator outputs
// - unimplemented bits read zero, ignore writes
// - comparators 2 and 3 only when present
// - five-bit level gives 32 reference levels
// - source select: external pins or analog rails
// - external: low plus code/32 of span
package csv_pkg;

    localparam int unsigned NUM_CMP = 3;

    localparam logic [7:0] OFF_CTRL1  = 8'h00;
    localparam logic [7:0] OFF_CTRL2  = 8'h04;
    localparam logic [7:0] OFF_CTRL3  = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_REFCON = 8'h10;
    localparam logic [7:0] OFF_BUFCON = 8'h14;

    // comparator control fields
    localparam int unsigned CC_EVT_BIT   = 9;
    localparam int unsigned CC_OUT_BIT   = 8;
    localparam int unsigned CC_POL_LSB   = 6;
    localparam int unsigned CC_CH_LSB    = 0;
    localparam logic [15:0] CC_WMASK     = 16'h02C3;
    localparam logic [15:0] CC_RESET     = 16'h0000;

    // status fields
    localparam int unsigned ST_IDLE_BIT  = 15;
    localparam int unsigned ST_EVT_LSB   = 8;
    localparam int unsigned ST_OUT_LSB   = 0;
    localparam logic [15:0] ST_RESET     = 16'h0000;

    // reference and buffer control fields
    localparam int unsigned RC_EN_BIT    = 7;
    localparam int unsigned RC_OE_BIT    = 6;
    localparam int unsigned RC_SS_BIT    = 5;
    localparam logic [15:0] RC_WMASK     = 16'h00FF;
    localparam logic [15:0] RC_RESET     = 16'h0000;
    localparam logic [15:0] BC_WMASK     = 16'h0003;
    localparam logic [15:0] BC_RESET     = 16'h0000;

    localparam logic [1:0] AXI_OKAY   = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        CSV_CH_PIN_B   = 2'b00,
        CSV_CH_PIN_C   = 2'b01,
        CSV_CH_PIN_D   = 2'b10,
        CSV_CH_BANDGAP = 2'b11
    } csv_chan_e;

    typedef enum logic [1:0] {
        CSV_POL_OFF  = 2'b00,
        CSV_POL_RISE = 2'b01,
        CSV_POL_FALL = 2'b10,
        CSV_POL_ANY  = 2'b11
    } csv_pol_e;

    typedef struct packed {
        logic        power_on;
        logic        pin_output;
        logic        source_ext;
        logic [4:0]  level_code;
    } csv_ref_s;

    typedef struct packed {
        csv_chan_e   channel;
        logic [1:0]  bandgap_level;
    } csv_mux_s;

endpackage : csv_pkg

// >>> csv_regs.sv
// Purpose: control/status registers for three comparators and a 32-level reference
// Assumes: AXI4-Lite slave, one write and one read at a time
// Notes:   analog mux and ladder are driven by the select outputs
`timescale 1ns/100ps
`default_nettype none
module csv_regs (
    input  wire logic                 clk_sys,
    input  wire logic                 sys_rst,
    // axi4-lite
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output var  logic                 s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output var  logic                 s_axi_wready,
    output var  logic [1:0]           s_axi_bresp,
    output var  logic                 s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output var  logic                 s_axi_arready,
    output var  logic [31:0]          s_axi_rdata,
    output var  logic [1:0]           s_axi_rresp,
    output var  logic                 s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // comparator side
    input  wire logic [2:0]           cmp_present,
    input  wire logic [2:0]           comparator_result,
    input  wire logic                 cpu_idle,
    output var  logic [2:0]           cmp_irq,
    output var  csv_pkg::csv_mux_s [2:0] cmp_mux,
    output var  csv_pkg::csv_ref_s    ref_ctrl
);
    import csv_pkg::*;

    // ------
    // storage
    // ------
    logic [15:0] ctrl_reg [NUM_CMP];
    logic        idle_interrupt_stop_reg;
    logic [15:0] refcon_reg;
    logic [15:0] bufcon_reg;
    logic [2:0]  res_sync;
    logic [2:0]  out_bits;
    logic [2:0]  evt_bits;
    logic [2:0]  evt_prev_reg;
    logic [2:0]  evt_clear;

    // ------
    // write channel
    // ------
    logic        aw_held_reg;
    logic        w_held_reg;
    logic [7:0]  waddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        do_write;

    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a == OFF_CTRL1) || (a == OFF_CTRL2) || (a == OFF_CTRL3) ||
                     (a == OFF_STATUS) || (a == OFF_REFCON) || (a == OFF_BUFCON);
    endfunction : addr_known

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [1:0] strb, input logic [15:0] mask);
        logic [15:0] lanes;
        lanes = {{8{strb[1]}}, {8{strb[0]}}} & mask;
        merge = (old & ~lanes) | (nw & lanes);
    endfunction : merge

    function automatic logic [1:0] cmp_index(input logic [7:0] a);
        cmp_index = a[3:2];
    endfunction : cmp_index

    assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            aw_held_reg   <= 1'b0;
            waddr_reg     <= 8'h00;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_reg && !s_axi_awready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                waddr_reg   <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            w_held_reg   <= 1'b0;
            wdata_reg    <= 32'h0000_0000;
            wstrb_reg    <= 4'h0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_held_reg && !s_axi_wready;
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end else if (do_write) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= AXI_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_known(waddr_reg) ? AXI_OKAY : AXI_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------
    // comparator control registers
    // ------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CMP; gi++) begin : g_cmp
            logic hit_wr;
            assign hit_wr = do_write && (waddr_reg == OFF_CTRL1 + 8'(4 * gi));

            csv_sync u_sync (
                .clk_sys (clk_sys),
                .sys_rst (sys_rst),
                .din     (comparator_result[gi]),
                .dout    (res_sync[gi])
            );

            csv_cmp_event u_evt (
                .clk_sys   (clk_sys),
                .sys_rst   (sys_rst),
                .present   (cmp_present[gi]),
                .result    (res_sync[gi]),
                .polarity  (csv_pol_e'(ctrl_reg[gi][CC_POL_LSB +: 2])),
                .evt_clear (evt_clear[gi]),
                .out_reg   (out_bits[gi]),
                .evt_reg   (evt_bits[gi])
            );

            // software may only clear the event flag
            assign evt_clear[gi] = hit_wr && wstrb_reg[1] && !wdata_reg[CC_EVT_BIT];

            always_ff @(posedge clk_sys or posedge sys_rst) begin
                if (sys_rst) begin
                    ctrl_reg[gi] <= CC_RESET;
                end else if (!cmp_present[gi]) begin
                    ctrl_reg[gi] <= CC_RESET;
                end else if (hit_wr) begin
                    ctrl_reg[gi] <= merge(ctrl_reg[gi], wdata_reg[15:0], wstrb_reg[1:0],
                                          CC_WMASK & ~(16'h0001 << CC_EVT_BIT));
                end
            end

            // rising event flag raises the interrupt unless idle-stop holds it
            always_ff @(posedge clk_sys or posedge sys_rst) begin
                if (sys_rst) begin
                    cmp_irq[gi] <= 1'b0;
                end else begin
                    cmp_irq[gi] <= evt_bits[gi] && !evt_prev_reg[gi]
                                   && !(cpu_idle && idle_interrupt_stop_reg);
                end
            end

            always_ff @(posedge clk_sys or posedge sys_rst) begin
                if (sys_rst) begin
                    cmp_mux[gi] <= '0;
                end else begin
                    cmp_mux[gi].channel       <= csv_chan_e'(ctrl_reg[gi][CC_CH_LSB +: 2]);
                    cmp_mux[gi].bandgap_level <= bufcon_reg[1:0] & {2{cmp_present[gi]}};
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            evt_prev_reg <= 3'b000;
        end else begin
            evt_prev_reg <= evt_bits;
        end
    end

    // ------
    // status, reference and buffer registers
    // ------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            idle_interrupt_stop_reg <= 1'b0;
        end else if (do_write && waddr_reg == OFF_STATUS && wstrb_reg[1]) begin
            idle_interrupt_stop_reg <= wdata_reg[ST_IDLE_BIT];
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            refcon_reg <= RC_RESET;
        end else if (do_write && waddr_reg == OFF_REFCON) begin
            refcon_reg <= merge(refcon_reg, wdata_reg[15:0], wstrb_reg[1:0], RC_WMASK);
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            bufcon_reg <= BC_RESET;
        end else if (do_write && waddr_reg == OFF_BUFCON) begin
            bufcon_reg <= merge(bufcon_reg, wdata_reg[15:0], wstrb_reg[1:0], BC_WMASK);
        end
    end

    // level code drives the ladder tap; source picks external pins or rails
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ref_ctrl <= '0;
        end else begin
            ref_ctrl.power_on   <= refcon_reg[RC_EN_BIT];
            ref_ctrl.pin_output <= refcon_reg[RC_OE_BIT];
            ref_ctrl.source_ext <= refcon_reg[RC_SS_BIT];
            ref_ctrl.level_code <= refcon_reg[4:0];
        end
    end

    // ------
    // read channel
    // ------
    function automatic logic [15:0] read_word(input logic [7:0] a);
        logic [15:0] st;
        st = 16'h0000;
        st[ST_IDLE_BIT] = idle_interrupt_stop_reg;
        st[ST_EVT_LSB +: 3] = evt_bits & cmp_present;
        st[ST_OUT_LSB +: 3] = out_bits & cmp_present;
        read_word = 16'h0000;
        if (a == OFF_CTRL1 || a == OFF_CTRL2 || a == OFF_CTRL3) begin
            read_word = ctrl_reg[cmp_index(a)] & CC_WMASK;
            read_word[CC_EVT_BIT] = evt_bits[cmp_index(a)];
            read_word[CC_OUT_BIT] = out_bits[cmp_index(a)];
        end else if (a == OFF_STATUS) begin
            read_word = st;
        end else if (a == OFF_REFCON) begin
            read_word = refcon_reg & RC_WMASK;
        end else if (a == OFF_BUFCON) begin
            read_word = bufcon_reg & BC_WMASK;
        end
    endfunction : read_word

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= AXI_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !s_axi_arvalid ? 1'b1 :
                             (!s_axi_rvalid && !s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= {16'h0000, read_word(s_axi_araddr)};
                s_axi_rresp   <= addr_known(s_axi_araddr) ? AXI_OKAY : AXI_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
            end
        end
    end
endmodule : csv_regs
`default_nettype wire

// >>> csv_regs_monitor.sv
// Purpose: port-level checks of csv_regs
// Assumes: aligned word accesses
// Notes:   bound to every csv_regs instance
`timescale 1ns/100ps
`default_nettype none
module csv_regs_monitor
    import csv_pkg::*;
(
    input  wire logic                    clk_sys,
    input  wire logic                    sys_rst,
    input  wire logic [7:0]              s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    input  wire logic                    s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    input  wire logic                    s_axi_wready,
    input  wire logic [1:0]              s_axi_bresp,
    input  wire logic                    s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [7:0]              s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    input  wire logic                    s_axi_arready,
    input  wire logic [31:0]             s_axi_rdata,
    input  wire logic [1:0]              s_axi_rresp,
    input  wire logic                    s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    input  wire logic [2:0]              cmp_present,
    input  wire logic [2:0]              cmp_irq,
    input  wire csv_pkg::csv_mux_s [2:0] cmp_mux,
    input  wire csv_pkg::csv_ref_s       ref_ctrl
);
    // ------
    // captured request fields
    // ------
    logic [7:0]  aw_q;
    logic [7:0]  ar_q;
    logic [7:0]  wd_q;
    logic        ws_q;
    logic [11:0] mux_bits;
    logic [11:0] pres_mask;

    assign mux_bits  = cmp_mux;
    assign pres_mask = {{4{cmp_present[2]}}, {4{cmp_present[1]}}, {4{cmp_present[0]}}};

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            aw_q <= 8'h00;
            ar_q <= 8'h00;
            wd_q <= 8'h00;
            ws_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
            if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
            if (s_axi_wvalid && s_axi_wready) begin
                wd_q <= s_axi_wdata[7:0];
                ws_q <= s_axi_wstrb[0];
            end
        end
    end

    // ------
    // properties
    // ------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    sequence s_ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_wr_done;
        $rose(s_axi_bvalid);
    endsequence

    property p_rd_answer;
        s_ar_take |=> s_axi_rvalid;
    endproperty
    property p_bvalid_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_rvalid_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_rdata_upper;
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
    endproperty
    property p_rd_resp;
        $rose(s_axi_rvalid) |-> s_axi_rresp == ((ar_q > OFF_BUFCON) ? AXI_SLVERR : AXI_OKAY)
            && (ar_q <= OFF_BUFCON || s_axi_rdata == 32'h0000_0000);
    endproperty
    property p_wr_resp;
        s_wr_done |-> s_axi_bresp == ((aw_q > OFF_BUFCON) ? AXI_SLVERR : AXI_OKAY);
    endproperty
    property p_ref_write;
        s_wr_done ##0 (aw_q == OFF_REFCON && ws_q) |=> ref_ctrl == wd_q;
    endproperty
    property p_irq_absent;
        (cmp_irq & ~cmp_present) == 3'h0;
    endproperty
    property p_mux_absent;
        (mux_bits & ~pres_mask) == 12'h000;
    endproperty
    property p_irq_pulse;
        cmp_irq != 3'h0 |=> (cmp_irq & $past(cmp_irq)) == 3'h0;
    endproperty

    a_rd_answer: assert property (p_rd_answer) else $error("read answer missing");
    a_bvalid_hold: assert property (p_bvalid_hold) else $error("bvalid dropped");
    a_rvalid_hold: assert property (p_rvalid_hold) else $error("rdata dropped");
    a_rdata_upper: assert property (p_rdata_upper) else $error("rdata upper set");
    a_rd_resp: assert property (p_rd_resp) else $error("read response wrong");
    a_wr_resp: assert property (p_wr_resp) else $error("write response wrong");
    a_ref_write: assert property (p_ref_write) else $error("ref outputs stale");
    a_irq_absent: assert property (p_irq_absent) else $error("absent irq");
    a_mux_absent: assert property (p_mux_absent) else $error("absent mux set");
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
endmodule : csv_regs_monitor

bind csv_regs csv_regs_monitor mon_u (.*);
`default_nettype wire

// >>> csv_sync.sv
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input asynchronous to clk_sys
// Notes:   output changes once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module csv_sync (
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic din,
    output var  logic dout
);
    import csv_pkg::*;

    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            dout <= 1'b0;
        end else if (s2_reg == s3_reg) begin
            dout <= s3_reg;
        end
    end
endmodule : csv_sync
`default_nettype wire

// >>> tb_top.sv
// Purpose: self-checking bench for csv_regs
// Assumes: aligned word accesses, fixed random seed
// Notes:   comparator inputs get 12 cycles to settle
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
    $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module tb_top;
    import csv_pkg::*;
    logic           clk_sys = 1'b0;
    logic           sys_rst = 1'b1;
    logic [7:0]     s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic           s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic           s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, cpu_idle = 1'b0;
    logic [31:0]    s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic [3:0]     s_axi_wstrb = 4'h0;
    logic           s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]     s_axi_bresp, s_axi_rresp;
    logic [2:0]     cmp_present = 3'h7, comparator_result = 3'h0, cmp_irq;
    csv_mux_s [2:0] cmp_mux;
    csv_ref_s       ref_ctrl;
    int             n_errors = 0, comparisons = 0;
    int             irq_cnt [3] = '{0, 0, 0};
    int             exp_irq [3] = '{0, 0, 0};
    logic [15:0]    d;
    logic [1:0]     r, p;
    logic [31:0]    rdv;
    logic [7:0]     a;

    csv_regs dut_u (.*);

    always #12.5 clk_sys = ~clk_sys;
    always @(negedge clk_sys) begin
        for (int i = 0; i < 3; i++) if (cmp_irq[i] === 1'b1) irq_cnt[i]++;
    end

    // ------
    // tasks and expectations
    // ------
    task automatic finish_test();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    function automatic logic fires(input logic [1:0] pol, input logic rising);
        return (pol == CSV_POL_ANY) || (pol == CSV_POL_RISE && rising) || (pol == CSV_POL_FALL && !rising);
    endfunction : fires

    function automatic logic [15:0] st_exp(input logic [2:0] e, input logic [2:0] o);
        return {5'h00, e, 5'h00, o};
    endfunction : st_exp

    task automatic wr(input logic [7:0] ad, input logic [15:0] dt, input logic [1:0] s, output logic [1:0] rs);
        logic ah, wh, a_ok, w_ok;
        int   n;
        a_ok = 1'b0;
        w_ok = 1'b0;
        n = 0;
        @(posedge clk_sys);
        s_axi_awaddr <= ad;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {16'h0000, dt};
        s_axi_wstrb <= {2'b00, s};
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(a_ok && w_ok) && n < 200) begin
            @(negedge clk_sys);
            ah = s_axi_awvalid && s_axi_awready;
            wh = s_axi_wvalid && s_axi_wready;
            @(posedge clk_sys);
            if (ah) begin a_ok = 1'b1; s_axi_awvalid <= 1'b0; end
            if (wh) begin w_ok = 1'b1; s_axi_wvalid <= 1'b0; end
            n++;
        end
        do begin @(negedge clk_sys); n++; end while (s_axi_bvalid !== 1'b1 && n < 400);
        rs = s_axi_bresp;
        @(posedge clk_sys);
        s_axi_bready <= 1'b0;
        `CHK(n < 400, 1'b1)
    endtask : wr

    task automatic rd(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] rs);
        int n;
        n = 0;
        @(posedge clk_sys);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin @(negedge clk_sys); n++; end while (s_axi_arready !== 1'b1 && n < 200);
        @(posedge clk_sys);
        s_axi_arvalid <= 1'b0;
        do begin @(negedge clk_sys); n++; end while (s_axi_rvalid !== 1'b1 && n < 400);
        dt = s_axi_rdata;
        rs = s_axi_rresp;
        @(posedge clk_sys);
        s_axi_rready <= 1'b0;
        `CHK(n < 400, 1'b1)
    endtask : rd

    task automatic rd_chk(input logic [7:0] ad, input logic [15:0] e);
        logic [31:0] dt;
        logic [1:0]  rs;
        rd(ad, dt, rs);
        `CHK(dt, {16'h0000, e})
        `CHK(rs, AXI_OKAY)
    endtask : rd_chk

    task automatic tog(input int c);
        @(posedge clk_sys);
        comparator_result[c] <= ~comparator_result[c];
        repeat (12) @(posedge clk_sys);
    endtask : tog

    // ------
    // main sequence
    // ------
    initial begin
        void'($urandom(42219));
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        for (int i = 0; i < 6; i++) rd_chk(8'(4 * i), 16'h0000);
        for (int i = 0; i < 10; i++) begin
            d = (i == 0) ? 16'hFFFF : 16'($urandom);
            wr(OFF_REFCON, d, 2'b11, r);
            rd_chk(OFF_REFCON, d & 16'h00FF);
            `CHK(ref_ctrl, d[7:0])
        end
        wr(OFF_REFCON, 16'h0000, 2'b10, r);
        `CHK(ref_ctrl, d[7:0])
        for (int c = 0; c < 3; c++) begin
            for (int ch = 0; ch < 4; ch++) begin
                d = (16'($urandom) & 16'hFF3C) | 16'(ch);
                wr(OFF_CTRL1 + 8'(4 * c), d, 2'b11, r);
                rd_chk(OFF_CTRL1 + 8'(4 * c), d & 16'h00C3);
                `CHK(cmp_mux[c].channel, 2'(ch))
            end
        end
        for (int b = 0; b < 4; b++) begin
            wr(OFF_BUFCON, (16'($urandom) & 16'hFFFC) | 16'(b), 2'b11, r);
            @(negedge clk_sys);
            for (int c = 0; c < 3; c++) `CHK(cmp_mux[c].bandgap_level, 2'(b))
        end
        wr(OFF_STATUS, 16'h7FFF, 2'b11, r);
        rd_chk(OFF_STATUS, 16'h0000);
        wr(OFF_STATUS, 16'hFFFF, 2'b11, r);
        rd_chk(OFF_STATUS, 16'h8000);
        wr(OFF_STATUS, 16'h0000, 2'b11, r);
        // rise, fall, any on comparators 1, 2, 3
        for (int c = 0; c < 3; c++) begin
            p = 2'(c + 1);
            a = OFF_CTRL1 + 8'(4 * c);
            wr(a, 16'h0000, 2'b11, r);
            tog(c);
            `CHK(irq_cnt[c], exp_irq[c])
            wr(a, {8'h00, p, 6'h00}, 2'b11, r);
            tog(c);
            exp_irq[c]++;
            `CHK(irq_cnt[c], exp_irq[c])
            rd_chk(OFF_STATUS, st_exp(3'(1 << c), comparator_result));
            rd_chk(a, {6'h00, 1'b1, comparator_result[c], p, 6'h00});
            for (int k = 0; k < 2; k++) begin
                wr(a, {8'h00, p, 6'h00}, 2'b11, r);
                tog(c);
                if (fires(p, comparator_result[c])) exp_irq[c]++;
                `CHK(irq_cnt[c], exp_irq[c])
            end
            wr(a, {8'h00, p, 6'h00}, 2'b11, r);
        end
        // interrupts held off in idle only with the stop bit
        wr(OFF_STATUS, 16'h8000, 2'b11, r);
        cpu_idle <= 1'b1;
        tog(0);
        `CHK(irq_cnt[0], exp_irq[0])
        wr(OFF_CTRL1, 16'h00C0, 2'b11, r);
        wr(OFF_STATUS, 16'h0000, 2'b11, r);
        tog(0);
        exp_irq[0]++;
        `CHK(irq_cnt[0], exp_irq[0])
        cpu_idle <= 1'b0;
        wr(8'h18, 16'hFFFF, 2'b11, r);
        `CHK(r, AXI_SLVERR)
        rd(8'h18, rdv, r);
        `CHK(rdv, 32'h0000_0000)
        `CHK(r, AXI_SLVERR)
        // variant with comparator 1 only
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        cmp_present <= 3'b001;
        comparator_result <= 3'b110;
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (12) @(posedge clk_sys);
        wr(OFF_CTRL3, 16'h00C3, 2'b11, r);
        rd_chk(OFF_CTRL3, 16'h0000);
        `CHK(cmp_mux[2], 4'h0)
        rd_chk(OFF_STATUS, 16'h0000);
        wr(OFF_CTRL1, 16'h0002, 2'b11, r);
        rd_chk(OFF_CTRL1, 16'h0002);
        finish_test();
    end

    initial begin
        #500000;
        n_errors++;
        $display("Error at %0t: watchdog expired", $time);
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
